// ==== logic/brk_pkg.sv ====
/*
 Shared types and constants of the hardware break comparator and branch trace.
 Assumes a 24-bit core address bus and a 16-bit core data bus.
*/
package brk_pkg;
   localparam int NUM_CH = 8;
   localparam int NUM_DATA_CH = 2;
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int TRACE_DEPTH = 16;
   localparam int TRACE_AW = 4;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h00_0000;
   localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
   localparam logic [TRACE_AW-1:0] PTR_RESET = 4'h0;
   localparam int HI_LSB = 8;
   localparam int HI_MSB = 15;
   localparam int LO_MSB = 7;

   typedef enum logic [1:0] {SIZE_WORD, SIZE_HIGH, SIZE_LOW} size_sel_t;
   typedef enum logic [1:0] {DIR_ANY, DIR_READ, DIR_WRITE} dir_sel_t;

   // One channel's settings as loaded by the debug host
   typedef struct packed {
      logic armed;
      logic data_en;
      size_sel_t size;
      dir_sel_t dir;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } chan_cfg_t;

   // One core bus cycle
   typedef struct packed {
      logic valid;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } bus_cyc_t;

   // Branch report from the core
   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] src;
   } branch_t;
endpackage

// ==== logic/hw_break_comparator.sv ====
/*
 Hardware break comparator: eight channels that watch the core bus and raise a
 registered break request with per-channel hits, plus a ring that records the
 source addresses of taken branches for the debug host to read back.
 Assumes the core presents at most one bus cycle per clock, marked by its valid
 flag, and that the debug host's side loads channel settings synchronously to
 mclk, one channel per write. Stepping, breakpoint resume and instruction start
 come from the core's execution control, also synchronous to mclk.
*/
// Notes on behaviour
// [RULE_01] Eight independent break channels request breaks.
// [RULE_02] Address equality satisfies address condition.
// [RULE_03] Data match by high, low byte or word.
// [RULE_04] Direction qualifier: read only or write only.
// [RULE_05] Only channels one and two compare data.
// [RULE_06] No breaks at all while single-stepping.
// [RULE_07] First instruction after breakpoint resume cannot break.
// [RULE_08] Host keeps test clock below system clock.
// [RULE_09] Branch sources recorded live, processor keeps running.
// [RULE_10] All enabled conditions must match together.
`timescale 1ns/10ps
`default_nettype none
module hw_break_comparator
   import brk_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Channel configuration from the debug host
   input wire logic cfg_we,
   input wire logic [2:0] cfg_sel,
   input wire brk_pkg::chan_cfg_t cfg_wdata,
   // Core bus and execution state
   input wire brk_pkg::bus_cyc_t bus,
   input wire logic stepping,
   input wire logic resume_from_bp,
   input wire logic insn_start,
   input wire brk_pkg::branch_t branch,
   // Break request
   output logic break_req,
   output logic [NUM_CH-1:0] break_hit,
   // Trace readback
   input wire logic [TRACE_AW-1:0] trace_rd_idx,
   output logic [ADDR_W-1:0] trace_rd_data,
   output logic [TRACE_AW-1:0] trace_wr_ptr,
   output logic trace_wrapped
);
   import brk_pkg::*;

   // Width of the channel index and the last slot of the trace ring
   localparam int SEL_W = $clog2(NUM_CH);
   localparam logic [TRACE_AW-1:0] PTR_LAST = TRACE_AW'(TRACE_DEPTH - 1);
   // Settings of a channel after reset: disarmed, data and direction conditions open, address zero
   localparam chan_cfg_t CFG_CLEAR = '{
      armed: 1'b0,
      data_en: 1'b0,
      size: SIZE_WORD,
      dir: DIR_ANY,
      addr: ADDR_RESET,
      data: DATA_RESET
   };

   chan_cfg_t cfg_q [NUM_CH];
   wire [NUM_CH-1:0] match;
   logic quiet;
   logic skip_q;
   logic [ADDR_W-1:0] trace_mem [TRACE_DEPTH];

   // One copy of the comparator per channel
   for (genvar g = 0; g < NUM_CH; g++)
   begin : g_chan
      logic a_ok;
      logic d_ok;
      logic r_ok;

      // Settings of this channel; the host loads one channel per write
      always_ff @(posedge mclk)
      begin
         if (reset)
         begin
            cfg_q[g] <= CFG_CLEAR;
         end
         else if (cfg_we && (cfg_sel == SEL_W'(g)))
         begin
            cfg_q[g] <= cfg_wdata;
            // A channel without a data comparator never keeps the enable
            if (g >= NUM_DATA_CH)
            begin
               cfg_q[g].data_en <= 1'b0; // see [RULE_05]
            end
         end
      end

      // Address condition
      always_comb
      begin
         a_ok = (bus.addr == cfg_q[g].addr); // see [RULE_02]
      end

      // Data condition; left open when the compare is off
      always_comb
      begin
         d_ok = 1'b1;
         if (cfg_q[g].data_en && (g < NUM_DATA_CH)) // see [RULE_05]
         begin
            case (cfg_q[g].size) // see [RULE_03]
               SIZE_HIGH: d_ok = bus.data[HI_MSB:HI_LSB] == cfg_q[g].data[HI_MSB:HI_LSB];
               SIZE_LOW: d_ok = bus.data[LO_MSB:0] == cfg_q[g].data[LO_MSB:0];
               default: d_ok = bus.data == cfg_q[g].data;
            endcase
         end
      end

      // Direction condition; bus write is high on a write cycle
      always_comb
      begin
         r_ok = 1'b1;
         case (cfg_q[g].dir) // see [RULE_04]
            DIR_READ: r_ok = !bus.write;
            DIR_WRITE: r_ok = bus.write;
            default: r_ok = 1'b1;
         endcase
      end

      // Open conditions count as met, so all three gate one hit
      assign match[g] = cfg_q[g].armed && bus.valid && a_ok && d_ok && r_ok; // see [RULE_10]
   end : g_chan

   // Suppression window: opened by a breakpoint resume, closed when the next
   // instruction starts; a resume in the same cycle as a start keeps it open
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         skip_q <= 1'b0;
      end
      else if (resume_from_bp)
      begin
         skip_q <= 1'b1; // see [RULE_07]
      end
      else if (insn_start)
      begin
         skip_q <= 1'b0;
      end
   end

   // Reasons to hold every channel off this cycle
   always_comb
   begin
      quiet = 1'b0;
      if (stepping) // see [RULE_06]
         quiet = 1'b1;
      // The resume cycle itself is covered before skip_q has risen
      if (skip_q || resume_from_bp) // see [RULE_07]
         quiet = 1'b1;
   end

   // Per-channel hits, one cycle after the matching bus cycle
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         break_hit <= '0;
      end
      else if (quiet)
      begin
         break_hit <= '0;
      end
      else
      begin
         break_hit <= match; // see [RULE_01]
      end
   end

   // Combined request, registered beside the hits so both line up
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         break_req <= 1'b0;
      end
      else if (quiet)
      begin
         break_req <= 1'b0;
      end
      else
      begin
         break_req <= |match; // see [RULE_01]
      end
   end

   // Branch trace write pointer; the ring is written on the fly so the
   // core never waits for it
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         trace_wr_ptr <= PTR_RESET;
      end
      else if (branch.valid)
      begin
         trace_wr_ptr <= trace_wr_ptr + 1'b1; // see [RULE_09]
      end
   end

   // Sticky once the ring has gone round; from then on the oldest entry is lost
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         trace_wrapped <= 1'b0;
      end
      else if (branch.valid && (trace_wr_ptr == PTR_LAST))
      begin
         trace_wrapped <= 1'b1; // see [RULE_09]
      end
   end

   // Ring storage; no reset, so slots never written read as unknown
   always_ff @(posedge mclk)
   begin
      if (branch.valid)
         trace_mem[trace_wr_ptr] <= branch.src; // see [RULE_09]
   end

   // Registered readback, one cycle behind the index
   always_ff @(posedge mclk)
   begin
      if (reset)
         trace_rd_data <= ADDR_RESET;
      else
         trace_rd_data <= trace_mem[trace_rd_idx];
   end
endmodule // hw_break_comparator
`default_nettype wire

// ==== tb/brk_assertions.sv ====
/* Checker for the break comparator; assumes it is bound onto the comparator top. */
`timescale 1ns/10ps
`default_nettype none
module brk_assertions
   import brk_pkg::*;
(
   // Causes
   input wire logic mclk,
   input wire logic reset,
   input wire brk_pkg::bus_cyc_t bus,
   input wire logic stepping,
   input wire logic resume_from_bp,
   input wire logic insn_start,
   input wire brk_pkg::branch_t branch,
   // Results
   input wire logic break_req,
   input wire logic [NUM_CH-1:0] break_hit,
   input wire logic [TRACE_AW-1:0] trace_wr_ptr,
   input wire logic trace_wrapped
);
   logic [TRACE_AW-1:0] ptr_next;
   assign ptr_next = trace_wr_ptr + TRACE_AW'(1);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (reset);
   sequence resumed_s;
      resume_from_bp ##1 !insn_start;
   endsequence
   sequence at_last_s;
      branch.valid && trace_wr_ptr == 4'hf;
   endsequence
   step_quiet_a: assert property (stepping |=> !break_req)
      else $error("break while stepping");
   resume_quiet_a: assert property (resume_from_bp |=> !break_req)
      else $error("break on resume");
   resume_hold_a: assert property (resumed_s |=> !break_req)
      else $error("break before next insn");
   idle_quiet_a: assert property (!bus.valid |=> break_hit == 0)
      else $error("hit on idle bus");
   req_any_a: assert property (break_req == |break_hit)
      else $error("request not or of hits");
   trace_step_a: assert property (branch.valid |=> trace_wr_ptr == $past(ptr_next))
      else $error("trace pointer not advanced");
   trace_hold_a: assert property (!branch.valid |=> $stable(trace_wr_ptr))
      else $error("trace pointer moved");
   wrap_set_a: assert property (at_last_s |=> trace_wrapped)
      else $error("wrap flag missed");
endmodule // brk_assertions
bind hw_break_comparator brk_assertions chk (
   .mclk(mclk),
   .reset(reset),
   .bus(bus),
   .stepping(stepping),
   .resume_from_bp(resume_from_bp),
   .insn_start(insn_start),
   .branch(branch),
   .break_req(break_req),
   .break_hit(break_hit),
   .trace_wr_ptr(trace_wr_ptr),
   .trace_wrapped(trace_wrapped)
);
`default_nettype wire

// ==== tb/core_model.sv ====
/* Core bus model; assumes the bench asks for each cycle on req. */
`timescale 1ns/10ps
`default_nettype none
module core_model
   import brk_pkg::*;
(
   // Requested cycle
   input wire logic mclk,
   input wire brk_pkg::bus_cyc_t req,
   // Core bus
   output var brk_pkg::bus_cyc_t bus
);
   bus_cyc_t last_q = 0;
   always_ff @(posedge mclk)
      last_q <= bus;
   // Idle bus toggles so stale values never look valid
   assign bus = req.valid ? req : {1'b0, ~last_q[40:0]};
endmodule // core_model
`default_nettype wire

// ==== tb/tb_top.sv ====
/* Random bench with reference model; assumes brk_pkg and core_model. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import brk_pkg::*;
   logic mclk = 0, reset = 1, cfg_we = 0, stepping = 0, resume_from_bp = 0, insn_start = 0;
   logic [2:0] cfg_sel = 0;
   logic [TRACE_AW-1:0] trace_rd_idx = 0, trace_wr_ptr, ptr = 0;
   logic [ADDR_W-1:0] trace_rd_data, er, ring [TRACE_DEPTH];
   logic [NUM_CH-1:0] break_hit, eh = 0;
   logic [DATA_W-1:0] msk;
   logic break_req, trace_wrapped, wrp = 0, supp = 0, ok, skip = 1;
   chan_cfg_t cfg_wdata = 0, cf [NUM_CH];
   bus_cyc_t req = 0, bus;
   branch_t branch = 0;
   int failures = 0, total_checks = 0, cyc = 0;
   always #2 mclk = ~mclk;
   core_model cm (
      .mclk(mclk),
      .req(req),
      .bus(bus)
   );
   hw_break_comparator uut (
      .mclk(mclk),
      .reset(reset),
      .cfg_we(cfg_we),
      .cfg_sel(cfg_sel),
      .cfg_wdata(cfg_wdata),
      .bus(bus),
      .stepping(stepping),
      .resume_from_bp(resume_from_bp),
      .insn_start(insn_start),
      .branch(branch),
      .break_req(break_req),
      .break_hit(break_hit),
      .trace_rd_idx(trace_rd_idx),
      .trace_rd_data(trace_rd_data),
      .trace_wr_ptr(trace_wr_ptr),
      .trace_wrapped(trace_wrapped)
   );
   task automatic flag(input string msg);
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
   endtask
   task automatic tally_and_finish;
      if (failures == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge mclk)
      if (++cyc == 1000)
      begin
         failures++;
         tally_and_finish();
      end
   initial
   begin
      void'($urandom(32'h4b9d));
      for (int i = 0; i < NUM_CH; i++)
         cf[i] = 0;
      repeat (5) @(negedge mclk);
      reset = 0;
      repeat (600)
      begin
         @(negedge mclk);
         total_checks += 4;
         if (break_hit !== eh)
            flag("break hits differ");
         if (break_req !== |eh)
            flag("break request differs");
         if (trace_wr_ptr !== ptr || trace_wrapped !== wrp)
            flag("trace pointer or wrap differs");
         if (!skip && trace_rd_data !== er)
            flag("trace readback differs");
         // Host writes come from its slower test clock: never two cycles running
         cfg_we = !cfg_we && $urandom % 4 == 0;
         cfg_sel = 3'($urandom);
         cfg_wdata = 46'({$urandom, $urandom});
         cfg_wdata.size = size_sel_t'(cfg_wdata.size % 3);
         cfg_wdata.dir = dir_sel_t'(cfg_wdata.dir % 3);
         cfg_wdata.addr = 24'($urandom % 4);
         cfg_wdata.data = 16'($urandom & 32'h0101);
         req = 42'({$urandom, $urandom});
         req.addr = 24'($urandom % 4);
         req.data = 16'($urandom & 32'h0101);
         stepping = $urandom % 8 == 0;
         resume_from_bp = $urandom % 16 == 0;
         insn_start = $urandom % 4 == 0;
         branch = 25'($urandom);
         trace_rd_idx = 4'($urandom);
         er = ring[trace_rd_idx];
         // Unwritten slots, or one rewritten on the same edge, are not compared
         skip = branch.valid && trace_rd_idx == ptr || $isunknown(er);
         for (int i = 0; i < NUM_CH; i++)
         begin
            ok = cf[i].armed && req.valid && req.addr == cf[i].addr;
            ok = ok && (cf[i].dir == DIR_ANY || (cf[i].dir == DIR_WRITE) == req.write);
            msk = cf[i].size == SIZE_HIGH ? 16'hff00 : cf[i].size == SIZE_LOW ? 16'h00ff : 16'hffff;
            if (i < NUM_DATA_CH && cf[i].data_en)
               ok = ok && ((req.data ^ cf[i].data) & msk) == 0;
            eh[i] = ok && !(stepping || resume_from_bp || supp);
         end
         supp = resume_from_bp || supp && !insn_start;
         if (cfg_we)
            cf[cfg_sel] = cfg_wdata;
         if (branch.valid)
         begin
            ring[ptr] = branch.src;
            wrp = wrp || ptr == 4'hf;
            ptr++;
         end
      end
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
